//--- core/wcf_pkg.sv
// package: constants, types and helpers of the width converting fifo
package wcf_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int WIDE_W = 36;
  localparam int NARROW_W = 9;
  localparam int MAJOR_W = 9;
  localparam int MINOR_W = 2;
  localparam int LEVEL_W = 4;
  localparam int LEVEL_LSB = 5;
  localparam int MEM_WORDS = 512;
  localparam logic [MAJOR_W-1:0] TALLY_MAX = 9'h1FF;
  localparam logic [MAJOR_W-1:0] TALLY_NEAR_FULL = 9'h1FE;
  localparam logic [MAJOR_W-1:0] TALLY_ONE = 9'h001;
  localparam logic [MINOR_W-1:0] MINOR_LAST = 2'h3;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam int CTRL_GATE_BIT = 0;
  localparam logic CTRL_GATE_RESET = 1'b0;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [LEVEL_W-1:0] level;
    logic gate;
    logic full;
    logic empty;
  } wcf_stat_s;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } wcf_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wcf_apb_rsp_s;
  // ---------------------------------------------------------------
  // gray conversion
  // ---------------------------------------------------------------
  function automatic logic [MAJOR_W-1:0] wcf_bin2gray(input logic [MAJOR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : wcf_bin2gray
  function automatic logic [MAJOR_W-1:0] wcf_gray2bin(input logic [MAJOR_W-1:0] g);
    logic [MAJOR_W-1:0] b;
    b[MAJOR_W-1] = g[MAJOR_W-1];
    for (int i = MAJOR_W - 2; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    return b;
  endfunction : wcf_gray2bin
endpackage : wcf_pkg

//--- core/wcf_fifo.sv
// module: width converting fifo, 36-bit and 9-bit ports, common or split clocks
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module wcf_fifo #(
  parameter bit WIDE_WRITE = 1'b1,
  parameter bit DUAL_CLK = 1'b0
) (
  input wire logic clk,
  input wire logic rd_clk,
  input wire logic rstn,
  input wire wcf_pkg::wcf_apb_req_s apb_req,
  output wcf_pkg::wcf_apb_rsp_s apb_rsp,
  input wire logic wr_en,
  input wire logic [wcf_pkg::WIDE_W-1:0] wr_data,
  input wire logic rd_en,
  output logic [wcf_pkg::WIDE_W-1:0] rd_data,
  output logic full,
  output logic empty,
  output logic [wcf_pkg::LEVEL_W-1:0] fill_level
);
  import wcf_pkg::*;

  logic rclk;
  logic [WIDE_W-1:0] mem [0:MEM_WORDS-1];
  logic [MAJOR_W-1:0] wr_major, rd_major, next_wr_major, next_rd_major;
  logic [MINOR_W-1:0] wr_minor, rd_minor;
  logic wr_ok, rd_ok, wr_step, rd_step;
  logic full_q, empty_q;
  logic [LEVEL_W-1:0] level_q;
  logic gate;
  logic empty_s1, empty_s2;
  wcf_stat_s stat;

  // ---------------------------------------------------------------
  // clocking of the read side
  // ---------------------------------------------------------------
  assign rclk = DUAL_CLK ? rd_clk : clk;

  // ---------------------------------------------------------------
  // request qualification and counter steps
  // ---------------------------------------------------------------
  assign wr_ok = wr_en && !full_q && !gate;
  assign rd_ok = rd_en && !empty_q;
  assign wr_step = wr_ok && (WIDE_WRITE || wr_minor == MINOR_LAST);
  assign rd_step = rd_ok && (!WIDE_WRITE || rd_minor == MINOR_LAST);
  assign next_wr_major = wr_major + MAJOR_W'(wr_step);
  assign next_rd_major = rd_major + MAJOR_W'(rd_step);

  // ---------------------------------------------------------------
  // write side: location counter and storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wr_major <= '0;
      wr_minor <= '0;
    end
    else
    begin
      wr_major <= next_wr_major;
      if (wr_ok && !WIDE_WRITE)
        wr_minor <= wr_minor + 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (wr_ok)
    begin
      if (WIDE_WRITE)
        mem[wr_major] <= wr_data;
      else
        mem[wr_major][wr_minor*NARROW_W +: NARROW_W] <= wr_data[NARROW_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // read side: location counter and output word
  // ---------------------------------------------------------------
  always_ff @(posedge rclk)
  begin
    if (!rstn)
    begin
      rd_major <= '0;
      rd_minor <= '0;
    end
    else
    begin
      rd_major <= next_rd_major;
      if (rd_ok && WIDE_WRITE)
        rd_minor <= rd_minor + 2'h1;
    end
  end

  always_ff @(posedge rclk)
  begin
    if (!rstn)
      rd_data <= '0;
    else if (rd_ok && WIDE_WRITE)
      rd_data <= {{(WIDE_W-NARROW_W){1'b0}}, mem[rd_major][rd_minor*NARROW_W +: NARROW_W]};
    else if (rd_ok)
      rd_data <= mem[rd_major];
  end

  // ---------------------------------------------------------------
  // flags and fill level
  // ---------------------------------------------------------------
  assign full = full_q || !rstn;
  assign empty = empty_q || !rstn;
  assign fill_level = level_q;

  generate
    if (!DUAL_CLK)
    begin : g_common
      logic [MAJOR_W-1:0] tally, next_tally;

      always_comb
      begin
        next_tally = tally;
        if (wr_step && !rd_step)
          next_tally = tally + TALLY_ONE;
        else if (rd_step && !wr_step)
          next_tally = tally - TALLY_ONE;
      end

      always_ff @(posedge clk)
      begin
        if (!rstn)
          tally <= '0;
        else
          tally <= next_tally;
      end

      always_ff @(posedge clk)
      begin
        if (!rstn)
          empty_q <= 1'b1;
        else if (rd_step && !wr_step && tally == TALLY_ONE)
          empty_q <= 1'b1;
        else if (wr_step && !rd_step)
          empty_q <= 1'b0;
      end

      always_ff @(posedge clk)
      begin
        if (!rstn)
          full_q <= 1'b0;
        else if (wr_step && !rd_step && tally == TALLY_NEAR_FULL)
          full_q <= 1'b1;
        else if (rd_step && !wr_step)
          full_q <= 1'b0;
      end

      assign level_q = tally[MAJOR_W-1:LEVEL_LSB];

      empty_last_a:
      assert property (@(posedge clk) disable iff (!rstn)
        rd_step && !wr_step && tally == TALLY_ONE |=> empty && tally == '0)
        else $error("empty did not rise after last read");
      empty_clear_a:
      assert property (@(posedge clk) disable iff (!rstn)
        wr_step && !rd_step |=> !empty ##0 tally == $past(tally) + TALLY_ONE)
        else $error("empty did not clear after write");
      full_max_a:
      assert property (@(posedge clk) disable iff (!rstn)
        tally == TALLY_MAX |-> full && !wr_ok)
        else $error("full not set at maximum tally");
      full_clear_a:
      assert property (@(posedge clk) disable iff (!rstn)
        full && rd_step && !wr_step |=> !full && tally == TALLY_NEAR_FULL)
        else $error("full did not clear after read");
      both_hold_a:
      assert property (@(posedge clk) disable iff (!rstn)
        rd_step && wr_step |=> $stable(empty) && $stable(full) && $stable(tally))
        else $error("flags moved on simultaneous read and write");
      level_bits_a:
      assert property (@(posedge clk) disable iff (!rstn)
        wr_step && !rd_step && tally == 9'h01F |=> fill_level == 4'h1)
        else $error("fill level not top tally bits");
      reset_flags_a:
      assert property (@(posedge clk)
        !rstn |-> empty && full ##1 (!rstn || (empty && !full)))
        else $error("flags wrong around reset");
      read_word_a:
      assert property (@(posedge clk) disable iff (!rstn)
        rd_ok && !WIDE_WRITE && !wr_ok |=> rd_data == mem[$past(rd_major)])
        else $error("read word not presented next cycle");
      minor_step_a:
      assert property (@(posedge clk) disable iff (!rstn)
        (wr_ok && !WIDE_WRITE) [*4] |=> wr_major == $past(wr_major, 4) + TALLY_ONE)
        else $error("narrow side did not step every fourth word");
      minor_read_a:
      assert property (@(posedge clk) disable iff (!rstn)
        (rd_ok && WIDE_WRITE) [*4] |=> rd_major == $past(rd_major, 4) + TALLY_ONE)
        else $error("narrow read side did not step every fourth word");
      refuse_full_a:
      assert property (@(posedge clk) disable iff (!rstn)
        wr_en && full |=> $stable(wr_major) && $stable(wr_minor))
        else $error("write taken while full");
    end
    else
    begin : g_dual
      logic [MAJOR_W-1:0] wr_gray, rd_gray;
      logic [MAJOR_W-1:0] rd_gray_s1, rd_gray_s2, wr_gray_s1, wr_gray_s2;
      logic [MAJOR_W-1:0] fill_diff;

      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          wr_gray <= '0;
          rd_gray_s1 <= '0;
          rd_gray_s2 <= '0;
        end
        else
        begin
          wr_gray <= wcf_bin2gray(next_wr_major);
          rd_gray_s1 <= rd_gray;
          rd_gray_s2 <= rd_gray_s1;
        end
      end

      always_ff @(posedge rclk)
      begin
        if (!rstn)
        begin
          rd_gray <= '0;
          wr_gray_s1 <= '0;
          wr_gray_s2 <= '0;
        end
        else
        begin
          rd_gray <= wcf_bin2gray(next_rd_major);
          wr_gray_s1 <= wr_gray;
          wr_gray_s2 <= wr_gray_s1;
        end
      end

      always_ff @(posedge rclk)
      begin
        if (!rstn)
          empty_q <= 1'b1;
        else
          empty_q <= wcf_bin2gray(next_rd_major) == wr_gray_s2;
      end

      always_ff @(posedge clk)
      begin
        if (!rstn)
          full_q <= 1'b0;
        else
          full_q <= wcf_bin2gray(next_wr_major + TALLY_ONE) == rd_gray_s2;
      end

      assign fill_diff = next_wr_major - wcf_gray2bin(rd_gray_s2);

      always_ff @(posedge clk)
      begin
        if (!rstn)
          level_q <= '0;
        else
          level_q <= fill_diff[MAJOR_W-1:LEVEL_LSB];
      end

      gray_step_a:
      assert property (@(posedge clk) disable iff (!rstn)
        !$stable(wr_gray) |-> $onehot(wr_gray ^ $past(wr_gray)))
        else $error("write gray location moved more than one bit");
      empty_fall_a:
      assert property (@(posedge rclk) disable iff (!rstn)
        wr_gray_s2 != rd_gray && !rd_step |=> !empty)
        else $error("empty held after write location captured");
    end
  endgenerate

  // ---------------------------------------------------------------
  // apb slave: status and control
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      empty_s1 <= 1'b1;
      empty_s2 <= 1'b1;
    end
    else
    begin
      empty_s1 <= empty_q;
      empty_s2 <= empty_s1;
    end
  end

  assign stat = '{level: level_q, gate: gate, full: full_q, empty: empty_s2};

  always_ff @(posedge clk)
  begin
    if (!rstn)
      gate <= CTRL_GATE_RESET;
    else if (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == CTRL_OFS)
      gate <= apb_req.pwdata[CTRL_GATE_BIT];
  end

  always_comb
  begin
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = 1'b0;
    apb_rsp.prdata = '0;
    if (apb_req.psel && apb_req.penable)
    begin
      if (apb_req.paddr == STATUS_OFS && !apb_req.pwrite)
        apb_rsp.prdata = 32'(stat);
      else if (apb_req.paddr == CTRL_OFS)
        apb_rsp.prdata = 32'(gate);
      else
        apb_rsp.pslverr = 1'b1;
    end
  end
endmodule : wcf_fifo
`default_nettype wire

//--- verif/wcf_peer.sv
// model: producer and consumer logic beside the fifo
`timescale 1ns/1ps
`default_nettype none
module wcf_peer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_go,
  input wire logic rd_go,
  input wire logic gated,
  input wire logic full,
  output logic wr_en,
  output logic [wcf_pkg::WIDE_W-1:0] wr_data,
  output logic rd_en
);
  import wcf_pkg::*;
  // -------------------------------------------------------------
  // word numbering, retried while not stored
  // -------------------------------------------------------------
  logic [8:0] n;
  logic [8:0] k;
  always_comb k = n + {8'h00, wr_en & ~full & ~gated};
  // -------------------------------------------------------------
  // request drive
  // -------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      n <= 9'h000;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      wr_data <= 36'h0;
    end
    else
    begin
      n <= k;
      wr_en <= wr_go;
      rd_en <= rd_go;
      if (wr_go)
        wr_data <= {k[6:0], 2'h3, k[6:0], 2'h2, k[6:0], 2'h1, k[6:0], 2'h0};
      else
        wr_data <= ~wr_data;
    end
  end
endmodule : wcf_peer
`default_nettype wire

//--- verif/tb.sv
// testbench: wide write, narrow read fifo with common and split clocks
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wcf_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr_go = 1'b0;
  logic rd_go = 1'b0;
  logic gated = 1'b0;
  wcf_apb_req_s apb_req = '0;
  wcf_apb_rsp_s apb_rsp;
  logic wr_en;
  logic [WIDE_W-1:0] wr_data;
  logic rd_en;
  logic [WIDE_W-1:0] rd_data;
  logic full;
  logic empty;
  logic [LEVEL_W-1:0] fill_level;
  int n_fail = 0;
  int check_count = 0;
  logic pend = 1'b0;
  logic [11:0] m = 12'h000;
  logic rclk2 = 1'b0;
  logic d_wr_en = 1'b0;
  logic d_rd_en = 1'b0;
  logic [WIDE_W-1:0] d_wr_data = 36'h0;
  wcf_apb_req_s d_apb_req = '0;
  logic [WIDE_W-1:0] d_rd_data;
  logic d_full;
  logic d_empty;
  logic [LEVEL_W-1:0] d_level;
  always #12.5 clk = ~clk;
  always #20 rclk2 = ~rclk2;
  wcf_fifo #(.WIDE_WRITE(1'b1), .DUAL_CLK(1'b0)) i_dut (.clk(clk), .rd_clk(clk), .rstn(rstn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
    .rd_data(rd_data), .full(full), .empty(empty), .fill_level(fill_level));
  wcf_peer i_peer (.clk(clk), .rstn(rstn), .wr_go(wr_go), .rd_go(rd_go), .gated(gated),
    .full(full), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en));
  wcf_fifo #(.WIDE_WRITE(1'b1), .DUAL_CLK(1'b1)) i_dut_dc (.clk(clk), .rd_clk(rclk2),
    .rstn(rstn), .apb_req(d_apb_req), .apb_rsp(), .wr_en(d_wr_en), .wr_data(d_wr_data),
    .rd_en(d_rd_en), .rd_data(d_rd_data), .full(d_full), .empty(d_empty), .fill_level(d_level));
  // -------------------------------------------------------------
  // compare and closing tasks
  // -------------------------------------------------------------
  task automatic chk_data(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag
  task automatic conclude();
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // -------------------------------------------------------------
  // access tasks
  // -------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] exp, input logic err);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do
      @(posedge clk);
    while (apb_rsp.pready !== 1'b1);
    if (!wr)
      chk_data({4'h0, apb_rsp.prdata}, {4'h0, exp});
    chk_flag(apb_rsp.pslverr, err);
    apb_req <= '0;
    @(posedge clk);
  endtask : apb
  task automatic burst(input logic w, input logic r, input int n);
    wr_go <= w;
    rd_go <= r;
    repeat (n) @(posedge clk);
    wr_go <= 1'b0;
    rd_go <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : burst
  task automatic dc_read(input logic [8:0] exp);
    d_rd_en <= 1'b1;
    @(posedge rclk2);
    d_rd_en <= 1'b0;
    @(posedge rclk2);
    chk_data(d_rd_data, {27'h0, exp});
  endtask : dc_read
  // -------------------------------------------------------------
  // narrow read data follows the written lanes in order
  // -------------------------------------------------------------
  always @(posedge clk)
  begin
    if (pend)
    begin
      chk_data(rd_data, {27'h0, m[8:0]});
      m <= m + 12'h001;
    end
    pend <= rstn & rd_en & ~empty;
  end
  // -------------------------------------------------------------
  // watchdog and tests
  // -------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    chk_flag(empty, 1'b1);
    chk_flag(full, 1'b1);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk_flag(empty, 1'b1);
    chk_flag(full, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0, 32'h1, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h1, 32'h0, 1'b0);
    gated <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0, 32'h1, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0, 32'h5, 1'b0);
    burst(1'b1, 1'b0, 2);
    chk_flag(empty, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h0, 32'h0, 1'b0);
    gated <= 1'b0;
    apb(1'b1, STATUS_OFS, 32'hF, 32'h0, 1'b1);
    apb(1'b0, 8'h08, 32'h0, 32'h0, 1'b1);
    burst(1'b1, 1'b0, 1);
    chk_flag(empty, 1'b0);
    burst(1'b1, 1'b0, 255);
    chk_data({32'h0, fill_level}, 36'h8);
    chk_flag(full, 1'b0);
    burst(1'b1, 1'b0, 260);
    chk_flag(full, 1'b1);
    chk_data({32'h0, fill_level}, 36'hF);
    burst(1'b0, 1'b1, 3);
    chk_flag(full, 1'b1);
    burst(1'b0, 1'b1, 1);
    chk_flag(full, 1'b0);
    burst(1'b1, 1'b0, 1);
    chk_flag(full, 1'b1);
    burst(1'b0, 1'b1, 2043);
    chk_flag(empty, 1'b0);
    burst(1'b0, 1'b1, 1);
    chk_flag(empty, 1'b1);
    chk_data({32'h0, fill_level}, 36'h0);
    burst(1'b0, 1'b1, 2);
    chk_data(rd_data, {27'h0, 9'h1FF});
    chk_data({24'h0, m}, 36'h800);
    burst(1'b1, 1'b0, 1);
    burst(1'b1, 1'b1, 8);
    chk_flag(empty, 1'b0);
    chk_data({32'h0, fill_level}, 36'h0);
    burst(1'b0, 1'b1, 28);
    chk_flag(empty, 1'b1);
    chk_data({24'h0, m}, 36'h824);
    d_wr_data <= {9'h003, 9'h002, 9'h001, 9'h000};
    d_wr_en <= 1'b1;
    @(posedge clk);
    d_wr_data <= {9'h007, 9'h006, 9'h005, 9'h004};
    @(posedge clk);
    d_wr_en <= 1'b0;
    repeat (6) @(posedge rclk2);
    chk_flag(d_empty, 1'b0);
    for (int i = 0; i < 8; i++)
      dc_read(9'(i));
    chk_flag(d_empty, 1'b1);
    @(posedge clk);
    d_wr_en <= 1'b1;
    repeat (520)
    begin
      @(posedge clk);
      d_wr_data <= d_wr_data + 36'h1;
    end
    d_wr_en <= 1'b0;
    @(posedge clk);
    chk_flag(d_full, 1'b1);
    chk_data({32'h0, d_level}, 36'hF);
    @(posedge rclk2);
    for (int i = 4; i < 8; i++)
      dc_read(9'(i));
    repeat (8) @(posedge clk);
    chk_flag(d_full, 1'b0);
    rstn <= 1'b0;
    @(posedge clk);
    chk_flag(full, 1'b1);
    chk_flag(d_empty, 1'b1);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk_flag(full, 1'b0);
    chk_flag(empty, 1'b1);
    chk_flag(d_full, 1'b0);
    chk_flag(d_empty, 1'b1);
    conclude();
  end
endmodule : tb
`default_nettype wire
